// >>> src/sms_defs.vh
// Constants for the deep standby controller: register offsets, fields, reset values, timing.
`ifndef SMS_DEFS_VH
`define SMS_DEFS_VH

// Register byte offsets on the APB slave.
`define SMS_OFF_CTRL        12'h000
`define SMS_OFF_STAT        12'h004
`define SMS_OFF_SETTLE      12'h008
`define SMS_OFF_CLKSEL      12'h00C

// Control register fields.
`define SMS_CTRL_WDT_SWSTOP 0
`define SMS_CTRL_SUB_EN     1
`define SMS_CTRL_SLOW_EN    2

// Clock-select register fields.
`define SMS_CS_WIDE_TMC     0
`define SMS_CS_WIDE_EXT     1
`define SMS_CS_TA_EXT       2
`define SMS_CS_TB_EXT       3
`define SMS_CS_TC_EXT       4
`define SMS_CS_AUXA_TMA     5
`define SMS_CS_RTC_SUB      6
`define SMS_CS_LCD_SUB      7
`define SMS_CS_RMT_SUB      8
`define SMS_CS_UARTA_TMA    9
`define SMS_CS_UARTB_TMA    10
`define SMS_CS_CSI_EXT      11
`define SMS_CS_TA_RUN       12
`define SMS_CS_AUXB_SLOW    13
`define SMS_CS_W            14

// Reset values.
`define SMS_CTRL_RST        3'h4
`define SMS_SETTLE_RST      3'h5
`define SMS_CLKSEL_RST      14'h0000

// Settling wait is 2^(SETTLE_BASE + select) cycles of the main clock.
`define SMS_SETTLE_BASE     4
`define SMS_SETTLE_SEL_W    3

`endif

// >>> src/sms_standby_ctrl.v
// Deep standby (stop mode) controller with APB registers and clock/run gating outputs.
//
// Overview of operation
// - Deep standby is entered only when the CPU core executes the stop instruction.
// - The stop instruction is accepted only while the CPU runs on the main system clock.
// - A pending unmasked interrupt at entry clears standby at once.
// - That clearing drops to halt and resumes only after the programmed settling wait.
// - In standby the CPU clock, fast oscillator, main crystal, external clock and flash stop.
// - In standby the sub and slow oscillators keep their state; RAM and port latches hold.
// - The wide timer runs in standby only on timer C output or its own external input.
// - Each 8-bit timer runs in standby only on its own external count input.
// - Auxiliary timer A runs in standby only on timer A output while timer A runs.
// - Real-time counter, display and remote receiver run in standby only on the sub clock.
// - The watchdog runs in standby unless the slow oscillator is software stoppable.
// - Both async serial ports run in standby only on timer A output while timer A runs.
// - The clocked serial port runs in standby only on an external serial clock.
// - An unmasked request leaves standby, waits for settling, then vectors or continues.
// - Any reset leaves standby and restarts from the reset vector.
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "sms_defs.vh"

module sms_standby_ctrl (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        srst_i,
  // APB slave.
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // CPU core and interrupt controller (same clock domain).
  input  wire        stop_exec_i,
  input  wire        cpu_on_main_i,
  input  wire        irq_pending_i,
  input  wire        irq_enable_i,
  output reg         stop_ack_o,
  output reg         resume_o,
  output reg         vector_o,
  output reg         halted_o,
  // Clock and memory control.
  output reg         cpu_clk_en_o,
  output reg         fast_osc_en_o,
  output reg         main_xtal_en_o,
  output reg         ext_clk_en_o,
  output reg         flash_en_o,
  output reg         sub_osc_en_o,
  output reg         slow_osc_en_o,
  output reg         ram_hold_o,
  output reg         port_hold_o,
  // Peripheral run enables.
  output reg         wide_timer_run_o,
  output reg         timer_a_run_o,
  output reg         timer_b_run_o,
  output reg         timer_c_run_o,
  output reg         aux_timer_a_run_o,
  output reg         aux_timer_b_run_o,
  output reg         aux_timer_c_run_o,
  output reg         rtc_run_o,
  output reg         lcd_run_o,
  output reg         remote_run_o,
  output reg         wdt_run_o,
  output reg         uart_a_run_o,
  output reg         uart_b_run_o,
  output reg         csi_run_o,
  output reg         buzzer_run_o,
  output reg         mcg_run_o,
  output reg         adc_run_o
);

  // Controller states.
  localparam [1:0] ST_RUN    = 2'b00;
  localparam [1:0] ST_STOP   = 2'b01;
  localparam [1:0] ST_SETTLE = 2'b10;
  // Code 2'b11 is unused; the default branch sends it back to run.

  reg  [1:0]                      state_q;
  reg  [1:0]                      state_d;
  reg  [2:0]                      ctrl_q;
  reg  [`SMS_SETTLE_SEL_W-1:0]    settle_q;
  reg  [`SMS_CS_W-1:0]            clksel_q;
  reg  [15:0]                     cnt_q;
  reg                             rejected_q;
  wire                            stop_req;
  wire                            apb_acc;
  wire                            apb_wr;
  wire [15:0]                     settle_lim;
  wire                            standby;
  wire                            settle_done;

  // Settling limit as a power of two; one function so width rules stay in one place.
  function [15:0] settle_cycles;
    input [`SMS_SETTLE_SEL_W-1:0] sel;
    begin
      settle_cycles = 16'h0001 << (sel + `SMS_SETTLE_BASE);
    end
  endfunction

  assign settle_lim  = settle_cycles(settle_q);
  // The end test is a bound, not an equality: a shorter select written during a wait
  // ends it at once instead of letting the counter run on until it wraps.
  assign settle_done = (cnt_q >= settle_lim - 16'h0001);
  assign apb_acc     = psel_i & penable_i;
  // Writes land only at the access edge, where the master samples pready.
  assign apb_wr      = apb_acc & pready_o & pwrite_i;
  // Entry needs the instruction and the main clock as CPU source.
  assign stop_req    = stop_exec_i & cpu_on_main_i;
  assign standby     = (state_q == ST_STOP);

  // Next-state logic; the interrupt check at entry turns stop into a settle wait.
  // Standby has no timeout: only a pending request or a reset ends it, so a core
  // with every source masked stays stopped until reset.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (stop_req) begin
          if (irq_pending_i) begin
            state_d = ST_SETTLE;
          end else begin
            state_d = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        if (irq_pending_i) begin
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settle_done) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // State, settle counter and CPU handshake; reset always returns to run.
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_q    <= ST_RUN;
      cnt_q      <= 16'h0000;
      stop_ack_o <= 1'b0;
      resume_o   <= 1'b0;
      vector_o   <= 1'b0;
      halted_o   <= 1'b0;
      rejected_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      // The acknowledge is a one-cycle pulse, one cycle after the instruction.
      stop_ack_o <= (state_q == ST_RUN) & stop_req;
      // A stop from the sub clock is refused and recorded for software; the flag is
      // sticky, and a new refusal wins over a clear that falls in the same cycle.
      if (stop_exec_i & ~cpu_on_main_i) begin
        rejected_q <= 1'b1;
      end else if (apb_wr & (paddr_i == `SMS_OFF_STAT) & pwdata_i[3]) begin
        rejected_q <= 1'b0;
      end
      if (state_q == ST_SETTLE) begin
        cnt_q <= cnt_q + 16'h0001;
      end else begin
        cnt_q <= 16'h0000;
      end
      // Resume pulse tells the core whether to vector or fall through.
      resume_o <= (state_q == ST_SETTLE) & settle_done;
      vector_o <= (state_q == ST_SETTLE) & settle_done & irq_enable_i;
      // Halted follows the next state so it rises together with the settle state.
      halted_o <= (state_d == ST_SETTLE);
    end
  end

  // Clock, memory and peripheral gating; registered so every output is a flop.
  // Every state-driven enable lags the state by one cycle: one extra clocked edge at entry is
  // traded for glitch-free outputs.
  always @(posedge clk_i) begin
    if (srst_i) begin
      cpu_clk_en_o      <= 1'b1;
      fast_osc_en_o     <= 1'b1;
      main_xtal_en_o    <= 1'b1;
      ext_clk_en_o      <= 1'b1;
      flash_en_o        <= 1'b1;
      sub_osc_en_o      <= 1'b0;
      slow_osc_en_o     <= 1'b1;
      ram_hold_o        <= 1'b0;
      port_hold_o       <= 1'b0;
      wide_timer_run_o  <= 1'b1;
      timer_a_run_o     <= 1'b1;
      timer_b_run_o     <= 1'b1;
      timer_c_run_o     <= 1'b1;
      aux_timer_a_run_o <= 1'b1;
      aux_timer_b_run_o <= 1'b1;
      aux_timer_c_run_o <= 1'b1;
      rtc_run_o         <= 1'b1;
      lcd_run_o         <= 1'b1;
      remote_run_o      <= 1'b1;
      wdt_run_o         <= 1'b1;
      uart_a_run_o      <= 1'b1;
      uart_b_run_o      <= 1'b1;
      csi_run_o         <= 1'b1;
      buzzer_run_o      <= 1'b1;
      mcg_run_o         <= 1'b1;
      adc_run_o         <= 1'b1;
    end else begin
      // Halt during settling also freezes the CPU clock until the wait ends.
      cpu_clk_en_o   <= ~(standby | state_q == ST_SETTLE);
      fast_osc_en_o  <= ~standby;
      main_xtal_en_o <= ~standby;
      ext_clk_en_o   <= ~standby;
      flash_en_o     <= ~standby;
      // Sub and slow oscillators follow software only; standby never touches them.
      sub_osc_en_o   <= ctrl_q[`SMS_CTRL_SUB_EN];
      slow_osc_en_o  <= ctrl_q[`SMS_CTRL_SLOW_EN];
      ram_hold_o     <= standby;
      port_hold_o    <= standby;
      wide_timer_run_o  <= ~standby | clksel_q[`SMS_CS_WIDE_TMC]
                           | clksel_q[`SMS_CS_WIDE_EXT];
      timer_a_run_o     <= ~standby | clksel_q[`SMS_CS_TA_EXT];
      timer_b_run_o     <= ~standby | clksel_q[`SMS_CS_TB_EXT];
      timer_c_run_o     <= ~standby | clksel_q[`SMS_CS_TC_EXT];
      // Timer A only runs in standby on its own input, so its users need that too.
      aux_timer_a_run_o <= ~standby | (clksel_q[`SMS_CS_AUXA_TMA]
                           & clksel_q[`SMS_CS_TA_EXT] & clksel_q[`SMS_CS_TA_RUN]);
      aux_timer_b_run_o <= ~standby | clksel_q[`SMS_CS_AUXB_SLOW];
      aux_timer_c_run_o <= ~standby;
      rtc_run_o         <= ~standby | clksel_q[`SMS_CS_RTC_SUB];
      lcd_run_o         <= ~standby | clksel_q[`SMS_CS_LCD_SUB];
      remote_run_o      <= ~standby | clksel_q[`SMS_CS_RMT_SUB];
      wdt_run_o         <= ~standby | ~ctrl_q[`SMS_CTRL_WDT_SWSTOP];
      uart_a_run_o      <= ~standby | (clksel_q[`SMS_CS_UARTA_TMA]
                           & clksel_q[`SMS_CS_TA_EXT] & clksel_q[`SMS_CS_TA_RUN]);
      uart_b_run_o      <= ~standby | (clksel_q[`SMS_CS_UARTB_TMA]
                           & clksel_q[`SMS_CS_TA_EXT] & clksel_q[`SMS_CS_TA_RUN]);
      csi_run_o         <= ~standby | clksel_q[`SMS_CS_CSI_EXT];
      buzzer_run_o      <= ~standby;
      mcg_run_o         <= ~standby;
      adc_run_o         <= 1'b1;
    end
  end

  // APB slave: zero wait states, unmapped addresses answer with an error.
  // Read data and the error flag are prepared at the setup edge so that they
  // stand, registered, through the access cycle in which the master samples them.
  always @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q    <= `SMS_CTRL_RST;
      settle_q  <= `SMS_SETTLE_RST;
      clksel_q  <= `SMS_CLKSEL_RST;
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      if (psel_i & ~penable_i) begin
        case (paddr_i)
          `SMS_OFF_CTRL: begin
            prdata_o <= {29'h0, ctrl_q};
          end
          `SMS_OFF_STAT: begin
            prdata_o <= {28'h0, rejected_q, halted_o, state_q};
          end
          `SMS_OFF_SETTLE: begin
            prdata_o <= {29'h0, settle_q};
          end
          `SMS_OFF_CLKSEL: begin
            prdata_o <= {18'h0, clksel_q};
          end
          default: begin
            pslverr_o <= 1'b1;
          end
        endcase
      end
      // Writes wait for the access edge: a transfer that the master abandons
      // before the answer leaves the registers untouched.
      if (apb_wr) begin
        case (paddr_i)
          `SMS_OFF_CTRL: begin
            ctrl_q <= pwdata_i[2:0];
          end
          `SMS_OFF_SETTLE: begin
            settle_q <= pwdata_i[`SMS_SETTLE_SEL_W-1:0];
          end
          `SMS_OFF_CLKSEL: begin
            clksel_q <= pwdata_i[`SMS_CS_W-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// >>> testbench/sms_standby_sva.sv
// Assertion checker for the deep standby controller.
`timescale 1ns/10ps
`default_nettype none
module sms_standby_sva (
  // Watched ports of the controller.
  input wire logic clk_i, srst_i, stop_exec_i, cpu_on_main_i, irq_enable_i, stop_ack_o,
  input wire logic resume_o, vector_o, halted_o, cpu_clk_en_o, flash_en_o, main_xtal_en_o,
  input wire logic sub_osc_en_o, ram_hold_o, port_hold_o, buzzer_run_o, adc_run_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Reset values are judged at the first edge after reset drops.
  property p_rst; $fell(srst_i) |-> cpu_clk_en_o && !ram_hold_o && !halted_o; endproperty
  a_rst: assert property (p_rst) else $error("standby kept after reset");
  property p_ack; stop_exec_i && cpu_on_main_i && cpu_clk_en_o && !halted_o |=> stop_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("stop not acknowledged");
  property p_rej; stop_exec_i && !cpu_on_main_i |=> !stop_ack_o; endproperty
  a_rej: assert property (p_rej) else $error("stop taken off main clock");
  property p_spur; !stop_exec_i |=> !stop_ack_o; endproperty
  a_spur: assert property (p_spur) else $error("ack without stop");
  // Gating lags the state by one cycle, hence the one-cycle delay.
  property p_gate; stop_ack_o && !halted_o |=> !cpu_clk_en_o && !flash_en_o &&
    !main_xtal_en_o && ram_hold_o && port_hold_o; endproperty
  a_gate: assert property (p_gate) else $error("clocks not gated in standby");
  property p_halt; halted_o |=> !cpu_clk_en_o; endproperty
  a_halt: assert property (p_halt) else $error("cpu clocked while settling");
  property p_res; resume_o |-> $past(halted_o); endproperty
  a_res: assert property (p_res) else $error("resume without settle");
  property p_vec; resume_o || vector_o |-> vector_o == (resume_o && irq_enable_i); endproperty
  a_vec: assert property (p_vec) else $error("vector choice wrong");
  property p_osc; stop_ack_o |=> $stable(sub_osc_en_o)[*4]; endproperty
  a_osc: assert property (p_osc) else $error("sub oscillator disturbed");
  property p_fix; ram_hold_o |-> !buzzer_run_o && adc_run_o; endproperty
  a_fix: assert property (p_fix) else $error("fixed peripherals wrong");
  c_stop: cover property (stop_ack_o ##1 !halted_o);
  c_vec: cover property (resume_o && vector_o);
  c_next: cover property (resume_o && !vector_o);
endmodule
bind sms_standby_ctrl sms_standby_sva u_sva (.clk_i, .srst_i, .stop_exec_i, .cpu_on_main_i,
  .irq_enable_i, .stop_ack_o, .resume_o, .vector_o, .halted_o, .cpu_clk_en_o, .flash_en_o,
  .main_xtal_en_o, .sub_osc_en_o, .ram_hold_o, .port_hold_o, .buzzer_run_o, .adc_run_o);
`default_nettype wire

// >>> testbench/sms_cpu_model.sv
// Behavioural CPU core and interrupt controller facing the standby block.
`timescale 1ns/10ps
`default_nettype none
module sms_cpu_model (
  // Clock and resume strobe from the block.
  input  wire logic clk_i,
  input  wire logic resume_i,
  // Requests towards the block.
  output var logic  stop_exec_o,
  output var logic  on_main_o,
  output var logic  irq_pend_o,
  output var logic  irq_en_o
);
  initial begin
    {stop_exec_o, on_main_o, irq_pend_o, irq_en_o} = 4'h4;
  end
  // The request flag stays set until the core resumes and services it.
  always @(posedge clk_i) begin
    if (resume_i) irq_pend_o <= 1'h0;
  end
  // One stop instruction is a single-cycle pulse.
  task exec_stop(input logic main);
    @(posedge clk_i);
    stop_exec_o <= 1'h1;
    on_main_o <= main;
    @(posedge clk_i);
    stop_exec_o <= 1'h0;
    on_main_o <= 1'h1;
  endtask
  // Raises an unmasked request; the enable level is held until the next one.
  task raise_irq(input logic en);
    @(posedge clk_i);
    irq_pend_o <= 1'h1;
    irq_en_o <= en;
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_stop_mode_standby_control.sv
// Self-checking bench for the deep standby controller.
`timescale 1ns/10ps
`default_nettype none
`include "sms_defs.vh"
module tb_stop_mode_standby_control;
  logic clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic stop_exec_i, cpu_on_main_i, irq_pending_i, irq_enable_i, stop_ack_o, resume_o;
  logic vector_o, halted_o, cpu_clk_en_o, fast_osc_en_o, main_xtal_en_o, ext_clk_en_o;
  logic flash_en_o, sub_osc_en_o, slow_osc_en_o, ram_hold_o, port_hold_o, wdt_run_o;
  logic wide_timer_run_o, timer_a_run_o, timer_b_run_o, timer_c_run_o, aux_timer_a_run_o;
  logic aux_timer_b_run_o, aux_timer_c_run_o, rtc_run_o, lcd_run_o, remote_run_o;
  logic uart_a_run_o, uart_b_run_o, csi_run_o, buzzer_run_o, mcg_run_o, adc_run_o;
  int bad_count, cmp_count, n;
  sms_standby_ctrl DUT (.*);
  sms_cpu_model u_cpu (.clk_i(clk_i), .resume_i(resume_o), .stop_exec_o(stop_exec_i),
    .on_main_o(cpu_on_main_i), .irq_pend_o(irq_pending_i), .irq_en_o(irq_enable_i));
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'h1, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'h1;
    do @(posedge clk_i); while (pready_o !== 1'h1);
    rd = prdata_o;
    err = pslverr_o;
    {psel_i, penable_i} <= 2'h0;
  endtask
  // Counts halted cycles until resume; the loop bound keeps a hang short.
  task settle(output int cnt);
    cnt = 0;
    for (int k = 0; k < 300 && resume_o !== 1'h1; k++) begin
      @(posedge clk_i);
      #1 cnt += (halted_o === 1'h1);
    end
  endtask
  task give_verdict;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task t_regs;
    apb(1'h0, `SMS_OFF_CTRL, 32'h0);
    chk(rd, 32'h4);
    apb(1'h0, `SMS_OFF_SETTLE, 32'h0);
    chk(rd, 32'h5);
    apb(1'h0, `SMS_OFF_CLKSEL, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'h0);
    apb(1'h0, 12'h010, 32'h0);
    chk(err, 1'h1);
  endtask
  task t_reject;
    u_cpu.exec_stop(1'h0);
    #1 chk(stop_ack_o, 1'h0);
    apb(1'h0, `SMS_OFF_STAT, 32'h0);
    chk(rd[3:0], 4'h8);
    apb(1'h1, `SMS_OFF_STAT, 32'h8);
    apb(1'h0, `SMS_OFF_STAT, 32'h0);
    chk(rd[3:0], 4'h0);
  endtask
  // Standby under several clock selections and settle lengths.
  task t_periph;
    logic [13:0] tbl [4];
    logic [13:0] cs;
    logic r;
    tbl = '{14'h3FFF, 14'h0000, 14'h1000, 14'h2A55};
    for (int i = 0; i < 4; i++) begin
      cs = tbl[i];
      r = cs[12] & cs[2];
      apb(1'h1, `SMS_OFF_CTRL, 32'h4 | i[0]);
      apb(1'h1, `SMS_OFF_CLKSEL, {18'h0, cs});
      apb(1'h1, `SMS_OFF_SETTLE, i);
      u_cpu.exec_stop(1'h1);
      #1 chk(stop_ack_o, 1'h1);
      @(posedge clk_i);
      #1 chk({cpu_clk_en_o, fast_osc_en_o, main_xtal_en_o, ext_clk_en_o, flash_en_o,
        ram_hold_o, port_hold_o, sub_osc_en_o, slow_osc_en_o}, 9'h00D);
      chk({wide_timer_run_o, timer_c_run_o, timer_b_run_o, timer_a_run_o, aux_timer_a_run_o,
        aux_timer_b_run_o, remote_run_o, lcd_run_o, rtc_run_o, uart_b_run_o, uart_a_run_o,
        csi_run_o}, {cs[0] | cs[1], cs[4:2], cs[5] & r, cs[13], cs[8:6], cs[10:9] & {r, r},
        cs[11]});
      chk({aux_timer_c_run_o, buzzer_run_o, mcg_run_o, adc_run_o, wdt_run_o},
        {4'h1, ~i[0]});
      u_cpu.raise_irq(i[0]);
      settle(n);
      chk(n, 1 << (4 + i));
      chk(vector_o, i[0]);
      // One cycle after resume the core is clocked again and nothing is held.
      @(posedge clk_i);
      #1 chk({cpu_clk_en_o, flash_en_o, ram_hold_o, buzzer_run_o}, 4'hD);
    end
  endtask
  task t_pending;
    u_cpu.raise_irq(1'h1);
    u_cpu.exec_stop(1'h1);
    #1 chk({stop_ack_o, halted_o}, 2'h3);
    settle(n);
    // One halted cycle was already seen at entry, before the count began.
    chk(n + 1, 32'h80);
  endtask
  task t_reset;
    u_cpu.exec_stop(1'h1);
    @(posedge clk_i);
    srst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'h0;
    #1 chk({cpu_clk_en_o, ram_hold_o, halted_o}, 3'h4);
    @(posedge clk_i);
    #1 chk({cpu_clk_en_o, ram_hold_o, halted_o, stop_ack_o}, 4'h8);
    apb(1'h0, `SMS_OFF_STAT, 32'h0);
    chk(rd[3:0], 4'h0);
    apb(1'h0, `SMS_OFF_CTRL, 32'h0);
    chk(rd, 32'h4);
  endtask
  // Reset for 20 cycles, then the scenarios in turn.
  initial begin
    {srst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {4'h8, 12'h0, 32'h0};
    repeat (20) @(posedge clk_i);
    srst_i <= 1'h0;
    t_regs();
    t_reject();
    t_periph();
    t_pending();
    t_reset();
    give_verdict();
  end
  // Watchdog: the scenarios need far fewer than 20000 cycles.
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
